// file: core/cob_pkg.sv
// Shared constants and types for the CANopen identifier master.
// Assumes a single 250 MHz system clock; nothing here is clocked.
package cob_pkg;

  // ---------------------------------------------------------------
  // Identifier layout
  // ---------------------------------------------------------------
  localparam int COB_ID_W = 11;
  localparam int COB_FC_W = 4;
  localparam int COB_NODE_W = 7;
  localparam int COB_FC_LSB = 7;
  localparam int COB_NUM_KIND = 14;

  // Object kinds, used as table index
  typedef enum logic [3:0] {
    K_NMT = 4'h0, K_SYNC = 4'h1, K_EMCY = 4'h2,
    K_TPDO1 = 4'h3, K_RPDO1 = 4'h4, K_TPDO2 = 4'h5, K_RPDO2 = 4'h6,
    K_TPDO3 = 4'h7, K_RPDO3 = 4'h8, K_TPDO4 = 4'h9, K_RPDO4 = 4'ha,
    K_SDO_TX = 4'hb, K_SDO_RX = 4'hc, K_GUARD = 4'hd
  } cob_kind_t;

  // Function codes per kind, entry index equals the kind
  localparam logic [COB_NUM_KIND*4-1:0] COB_FC_TAB = 56'he_c_b_a_9_8_7_6_5_4_3_1_0_0;
  // Shared identifiers that carry no node address
  localparam logic [10:0] COB_ID_NMT = 11'h000;
  localparam logic [10:0] COB_ID_SYNC = 11'h080;
  // Kinds that the node sends and this master receives
  localparam logic [13:0] COB_RX_MASK = 14'h2_aac;
  // Lowest and highest legal node address
  localparam logic [6:0] COB_NODE_MIN = 7'h01;
  localparam logic [6:0] COB_NODE_MAX = 7'h7f;

  // ---------------------------------------------------------------
  // Frame payload lengths in bytes
  // ---------------------------------------------------------------
  localparam logic [3:0] COB_LEN_NMT = 4'h2;
  localparam logic [3:0] COB_LEN_SYNC = 4'h0;
  localparam logic [3:0] COB_LEN_PDO = 4'h4;
  localparam logic [3:0] COB_LEN_SDO = 4'h4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int COB_CLK_MHZ = 250;
  localparam int COB_SYNC_PERIOD_US = 1000;
  localparam int COB_GUARD_TIMEOUT_US = 100000;
  localparam int COB_SYNC_CYC = COB_SYNC_PERIOD_US * COB_CLK_MHZ;
  localparam int COB_GUARD_CYC = COB_GUARD_TIMEOUT_US * COB_CLK_MHZ;

  // Default identifier of a kind for a node address
  function automatic logic [10:0] cob_default_id(input cob_kind_t k, input logic [6:0] node);
    logic [3:0] fc;
    fc = COB_FC_TAB[k*4 +: 4];
    if (k == K_NMT) cob_default_id = COB_ID_NMT;
    else if (k == K_SYNC) cob_default_id = COB_ID_SYNC;
    else cob_default_id = {fc, node};
  endfunction : cob_default_id

endpackage : cob_pkg

// file: core/cob_host.sv
// CANopen master side: builds identifiers of outgoing frames and sorts
// incoming frames from one slave node by object kind.
// Assumes a CAN controller on the same clock with a valid/ready transmit
// port and a one-cycle receive strobe.
//
// How it works
// - Identifiers are eleven bits wide
// - Bits ten to seven hold function code
// - Bits six to zero hold node address
// - NMT uses zero, SYNC uses 80h
// - PDO1 transmit 0011, receive 0100
// - PDO2 transmit 0101, receive 0110
// - PDO3 transmit 0111, receive 1000
// - PDO4 transmit 1001, receive 1010
// - SDO response 1011, request 1100
// - Identifiers are reprogrammable, matched from table
// - SDO request states index and sub-index
// - PDO outranks SDO in arbitration
// - PDO carries mapped data, no index
// - SYNC producer sends SYNC periodically
// - Master commands state, node shows alive
`timescale 1ns/1ns
module cob_host
  import cob_pkg::*;
#(
  parameter int unsigned SYNC_CYC = COB_SYNC_CYC,
  parameter int unsigned GUARD_CYC = COB_GUARD_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Identifier configuration
  input wire logic i_cfg_load_dflt,
  input wire logic [6:0] i_node_addr,
  input wire logic i_cfg_wr,
  input wire logic [3:0] i_cfg_kind,
  input wire logic [10:0] i_cfg_id,
  output logic o_addr_err,
  // Requests to send
  input wire logic i_sync_en,
  input wire logic i_nmt_req,
  input wire logic [7:0] i_nmt_cmd,
  input wire logic i_pdo_req,
  input wire logic [1:0] i_pdo_num,
  input wire logic [31:0] i_pdo_data,
  input wire logic i_sdo_req,
  input wire logic [7:0] i_sdo_cmd,
  input wire logic [15:0] i_sdo_index,
  input wire logic [7:0] i_sdo_sub,
  // Transmit port to the CAN controller
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic [10:0] o_tx_id,
  output logic [3:0] o_tx_len,
  output logic [31:0] o_tx_data,
  // Receive port from the CAN controller
  input wire logic i_rx_valid,
  input wire logic [10:0] i_rx_id,
  output logic o_rx_hit,
  output logic [3:0] o_rx_kind,
  output logic o_emcy_evt,
  output logic o_node_lost
);

  // ---------------------------------------------------------------
  // Identifier table
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} cob_state_t;

  logic [10:0] cob_id_r [COB_NUM_KIND];
  logic [10:0] cob_id_nxt [COB_NUM_KIND];
  logic addr_err_r, addr_err_nxt;
  logic addr_ok;

  assign addr_ok = (i_node_addr >= COB_NODE_MIN) && (i_node_addr <= COB_NODE_MAX);

  // Load defaults or one programmed value
  always_comb begin
    addr_err_nxt = addr_err_r;
    for (int k = 0; k < COB_NUM_KIND; k++) begin
      cob_id_nxt[k] = cob_id_r[k];
      if (i_cfg_load_dflt && addr_ok) begin
        cob_id_nxt[k] = cob_default_id(cob_kind_t'(k), i_node_addr);
      end
      if (i_cfg_wr && (i_cfg_kind == 4'(k))) begin
        cob_id_nxt[k] = i_cfg_id;
      end
    end
    if (i_cfg_load_dflt) begin
      addr_err_nxt = !addr_ok;
    end
  end

  // Register the table
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      for (int k = 0; k < COB_NUM_KIND; k++) cob_id_r[k] <= 11'h000;
      addr_err_r <= 1'b0;
    end else begin
      for (int k = 0; k < COB_NUM_KIND; k++) cob_id_r[k] <= cob_id_nxt[k];
      addr_err_r <= addr_err_nxt;
    end
  end

  // ---------------------------------------------------------------
  // SYNC period divider
  // ---------------------------------------------------------------
  logic [31:0] sync_cnt_r, sync_cnt_nxt;
  logic sync_tick;

  // Count one period, tick once per period
  always_comb begin
    sync_tick = 1'b0;
    sync_cnt_nxt = sync_cnt_r + 32'h0000_0001;
    if (!i_sync_en) begin
      sync_cnt_nxt = 32'h0000_0000;
    end else if (sync_cnt_r >= SYNC_CYC - 1) begin
      sync_cnt_nxt = 32'h0000_0000;
      sync_tick = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) sync_cnt_r <= 32'h0000_0000;
    else sync_cnt_r <= sync_cnt_nxt;
  end

  // ---------------------------------------------------------------
  // Transmit arbitration and frame build
  // ---------------------------------------------------------------
  // Pending bits: 3 NMT, 2 SYNC, 1 PDO, 0 SDO
  logic [3:0] pend_r, pend_nxt, pend_set, pend_clr;
  cob_state_t state_r, state_nxt;
  cob_kind_t tx_kind_r, tx_kind_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [10:0] tx_id_r, tx_id_nxt;
  logic [3:0] tx_len_r, tx_len_nxt;
  logic [31:0] tx_data_r, tx_data_nxt;
  logic [7:0] nmt_cmd_r, nmt_cmd_nxt;
  logic [1:0] pdo_num_r, pdo_num_nxt;
  logic [31:0] pdo_data_r, pdo_data_nxt;
  logic [31:0] sdo_word_r, sdo_word_nxt;
  cob_kind_t pdo_kind;

  assign pend_set = {i_nmt_req, sync_tick, i_pdo_req, i_sdo_req};
  assign pdo_kind = cob_kind_t'(4'(K_RPDO1) + 4'({pdo_num_r, 1'b0}));

  // Choose highest pending kind and drive the frame
  always_comb begin
    state_nxt = state_r;
    pend_clr = 4'h0;
    tx_kind_nxt = tx_kind_r;
    tx_valid_nxt = tx_valid_r;
    tx_id_nxt = tx_id_r;
    tx_len_nxt = tx_len_r;
    tx_data_nxt = tx_data_r;
    nmt_cmd_nxt = i_nmt_req ? i_nmt_cmd : nmt_cmd_r;
    pdo_num_nxt = i_pdo_req ? i_pdo_num : pdo_num_r;
    pdo_data_nxt = i_pdo_req ? i_pdo_data : pdo_data_r;
    sdo_word_nxt = i_sdo_req ? {i_sdo_sub, i_sdo_index, i_sdo_cmd} : sdo_word_r;
    case (state_r)
      ST_IDLE: begin
        if (pend_r != 4'h0) begin
          state_nxt = ST_SEND;
          tx_valid_nxt = 1'b1;
          if (pend_r[3]) begin
            pend_clr = 4'h8;
            tx_kind_nxt = K_NMT;
            tx_id_nxt = cob_id_r[K_NMT];
            tx_len_nxt = COB_LEN_NMT;
            tx_data_nxt = {16'h0000, 1'b0, i_node_addr, nmt_cmd_r};
          end else if (pend_r[2]) begin
            pend_clr = 4'h4;
            tx_kind_nxt = K_SYNC;
            tx_id_nxt = cob_id_r[K_SYNC];
            tx_len_nxt = COB_LEN_SYNC;
            tx_data_nxt = 32'h0000_0000;
          end else if (pend_r[1]) begin
            pend_clr = 4'h2;
            tx_kind_nxt = pdo_kind;
            tx_id_nxt = cob_id_r[pdo_kind];
            tx_len_nxt = COB_LEN_PDO;
            tx_data_nxt = pdo_data_r;
          end else begin
            pend_clr = 4'h1;
            tx_kind_nxt = K_SDO_RX;
            tx_id_nxt = cob_id_r[K_SDO_RX];
            tx_len_nxt = COB_LEN_SDO;
            tx_data_nxt = sdo_word_r;
          end
        end
      end
      ST_SEND: begin
        if (i_tx_ready) begin
          tx_valid_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        tx_valid_nxt = 1'b0;
      end
    endcase
    pend_nxt = (pend_r & ~pend_clr) | pend_set; // Set wins over clear
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      pend_r <= 4'h0;
      tx_kind_r <= K_NMT;
      tx_valid_r <= 1'b0;
      tx_id_r <= 11'h000;
      tx_len_r <= 4'h0;
      tx_data_r <= 32'h0000_0000;
      nmt_cmd_r <= 8'h00;
      pdo_num_r <= 2'h0;
      pdo_data_r <= 32'h0000_0000;
      sdo_word_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      tx_kind_r <= tx_kind_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_id_r <= tx_id_nxt;
      tx_len_r <= tx_len_nxt;
      tx_data_r <= tx_data_nxt;
      nmt_cmd_r <= nmt_cmd_nxt;
      pdo_num_r <= pdo_num_nxt;
      pdo_data_r <= pdo_data_nxt;
      sdo_word_r <= sdo_word_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Receive classification and node watchdog
  // ---------------------------------------------------------------
  logic any_hit;
  logic [3:0] hit_kind;
  logic rx_hit_r, rx_hit_nxt;
  logic [3:0] rx_kind_r, rx_kind_nxt;
  logic emcy_r, emcy_nxt;
  logic lost_r, lost_nxt;
  logic [31:0] guard_cnt_r, guard_cnt_nxt;

  // Match against node-sent kinds only
  always_comb begin
    any_hit = 1'b0;
    hit_kind = 4'h0;
    for (int k = 0; k < COB_NUM_KIND; k++) begin
      if (COB_RX_MASK[k] && (i_rx_id == cob_id_r[k])) begin
        any_hit = 1'b1;
        hit_kind = 4'(k);
      end
    end
    rx_hit_nxt = i_rx_valid && any_hit;
    rx_kind_nxt = rx_hit_nxt ? hit_kind : rx_kind_r;
    emcy_nxt = rx_hit_nxt && (hit_kind == K_EMCY);
    guard_cnt_nxt = guard_cnt_r;
    lost_nxt = lost_r;
    if (rx_hit_nxt && (hit_kind == K_GUARD)) begin
      guard_cnt_nxt = 32'h0000_0000;
      lost_nxt = 1'b0;
    end else if (guard_cnt_r >= GUARD_CYC - 1) begin
      lost_nxt = 1'b1;
    end else begin
      guard_cnt_nxt = guard_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rx_hit_r <= 1'b0;
      rx_kind_r <= 4'h0;
      emcy_r <= 1'b0;
      lost_r <= 1'b0;
      guard_cnt_r <= 32'h0000_0000;
    end else begin
      rx_hit_r <= rx_hit_nxt;
      rx_kind_r <= rx_kind_nxt;
      emcy_r <= emcy_nxt;
      lost_r <= lost_nxt;
      guard_cnt_r <= guard_cnt_nxt;
    end
  end

  // Outputs straight from flops
  assign o_addr_err = addr_err_r;
  assign o_tx_valid = tx_valid_r;
  assign o_tx_id = tx_id_r;
  assign o_tx_len = tx_len_r;
  assign o_tx_data = tx_data_r;
  assign o_rx_hit = rx_hit_r;
  assign o_rx_kind = rx_kind_r;
  assign o_emcy_evt = emcy_r;
  assign o_node_lost = lost_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_dflt_load;
    i_cfg_load_dflt && addr_ok && !i_cfg_wr;
  endsequence
  sequence s_frame_start;
    state_r == ST_IDLE && pend_r != 4'h0;
  endsequence

  a_tx_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_id))
    else $error("tx frame changed before accept");
  a_tx_from_tab: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_frame_start |=> o_tx_id == cob_id_r[tx_kind_r])
    else $error("tx id not from table");
  a_dflt_split: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_dflt_load |=> cob_id_r[K_RPDO1] == {4'h4, $past(i_node_addr)}
      && cob_id_r[K_SDO_RX] == {4'hc, $past(i_node_addr)})
    else $error("default id layout wrong");
  a_dflt_shared: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_dflt_load |=> cob_id_r[K_NMT] == 11'h000 && cob_id_r[K_SYNC] == 11'h080)
    else $error("shared ids wrong");
  a_pdo_over_sdo: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_frame_start and (pend_r[1:0] == 2'b11 && pend_r[3:2] == 2'b00)
      |=> tx_kind_r != K_SDO_RX && !pend_r[1] ##0 pend_r[0])
    else $error("sdo beat pdo");
  a_sdo_index: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_frame_start and (pend_r == 4'h1) |=> o_tx_data == $past(sdo_word_r))
    else $error("sdo index not sent");
  a_sync_pend: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    sync_tick |=> pend_r[2] || (o_tx_valid && tx_kind_r == K_SYNC))
    else $error("sync tick lost");
  a_rx_ignore: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_rx_valid && !any_hit |=> !o_rx_hit && !o_emcy_evt)
    else $error("unmatched frame acted on");
  a_addr_range: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_cfg_load_dflt && i_node_addr == 7'h00 |=> o_addr_err && $stable(cob_id_r[K_EMCY]))
    else $error("address 0 accepted");

endmodule : cob_host

// file: sim/cob_node_model.sv
// Behavioural slave node behind the CAN controller port of the host.
// Assumes the host clock; each frame is taken whole at its accept edge.
`timescale 1ns/1ns
module cob_node_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Own node address
  input wire logic [6:0] i_node_addr,
  // Frames from the host
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [10:0] i_tx_id,
  input wire logic [3:0] i_tx_len,
  input wire logic [31:0] i_tx_data,
  // Frames to the host
  output logic o_rx_valid,
  output logic [10:0] o_rx_id
);
  int dly = 0; // Accept delay, set by the bench
  int wcnt = 0;
  int cap_cnt = 0;
  logic [10:0] cap_id = 11'h000;
  logic [3:0] cap_len = 4'h0;
  logic [31:0] cap_data = 32'h0000_0000;

  // Idle ports at start
  initial begin
    o_tx_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_id = 11'h7ff;
  end

  // Accept after the set delay, keep the frame for the bench
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_tx_ready <= 1'b0;
      wcnt <= 0;
    end else if (o_tx_ready) begin
      o_tx_ready <= 1'b0;
      wcnt <= 0;
      cap_id <= i_tx_id;
      cap_len <= i_tx_len;
      cap_data <= i_tx_data;
      cap_cnt <= cap_cnt + 1;
    end else if (i_tx_valid) begin
      if (wcnt >= dly) begin
        o_tx_ready <= 1'b1;
      end else begin
        wcnt <= wcnt + 1;
      end
    end
  end

  // One frame for a single cycle, then a changed id on the idle port
  task automatic send_id(input logic [10:0] id);
    @(posedge i_sys_clk);
    #1;
    o_rx_valid = 1'b1;
    o_rx_id = id;
    @(posedge i_sys_clk);
    #1;
    o_rx_valid = 1'b0;
    o_rx_id = ~id;
  endtask : send_id

endmodule : cob_node_model

// file: sim/cob_host_test.sv
// Self-checking bench for the identifier host facing a node model.
// Assumes cob_pkg and cob_host compiled first; one 4 ns clock.
`timescale 1ns/1ns
module cob_host_test;
  import cob_pkg::*;

  localparam int unsigned SYNC_N = 20;
  localparam int unsigned GUARD_N = 200;

  // Design inputs and outputs
  logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_cfg_load_dflt = 1'b0, i_cfg_wr = 1'b0;
  logic i_sync_en = 1'b0, i_nmt_req = 1'b0, i_pdo_req = 1'b0, i_sdo_req = 1'b0;
  logic [6:0] i_node_addr = 7'h05;
  logic [3:0] i_cfg_kind = 4'h0;
  logic [10:0] i_cfg_id = 11'h000;
  logic [7:0] i_nmt_cmd = 8'h00, i_sdo_cmd = 8'h00, i_sdo_sub = 8'h00;
  logic [1:0] i_pdo_num = 2'h0;
  logic [31:0] i_pdo_data = 32'h0000_0000;
  logic [15:0] i_sdo_index = 16'h0000;
  logic i_tx_ready, i_rx_valid;
  logic [10:0] i_rx_id, o_tx_id;
  logic o_addr_err, o_tx_valid, o_rx_hit, o_emcy_evt, o_node_lost;
  logic [3:0] o_tx_len, o_rx_kind;
  logic [31:0] o_tx_data;
  int err_total = 0;
  int checks_done = 0;
  int seen = 0;

  cob_host #(.SYNC_CYC(SYNC_N), .GUARD_CYC(GUARD_N)) i_cob_host (
    .i_sys_clk, .i_resetn, .i_cfg_load_dflt, .i_node_addr, .i_cfg_wr, .i_cfg_kind,
    .i_cfg_id, .o_addr_err, .i_sync_en, .i_nmt_req, .i_nmt_cmd, .i_pdo_req, .i_pdo_num,
    .i_pdo_data, .i_sdo_req, .i_sdo_cmd, .i_sdo_index, .i_sdo_sub, .o_tx_valid,
    .i_tx_ready, .o_tx_id, .o_tx_len, .o_tx_data, .i_rx_valid, .i_rx_id, .o_rx_hit,
    .o_rx_kind, .o_emcy_evt, .o_node_lost
  );

  cob_node_model i_cob_node_model (
    .i_sys_clk, .i_resetn, .i_node_addr, .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready),
    .i_tx_id(o_tx_id), .i_tx_len(o_tx_len), .i_tx_data(o_tx_data),
    .o_rx_valid(i_rx_valid), .o_rx_id(i_rx_id)
  );

  // Free running clock
  always #2 i_sys_clk = ~i_sys_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic test_done();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Edges pass, then outputs settle
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : step

  task automatic rx(input logic [10:0] id);
    i_cob_node_model.send_id(id);
  endtask : rx

  task automatic load(input logic [6:0] a);
    i_node_addr = a;
    i_cfg_load_dflt = 1'b1;
    step(1);
    i_cfg_load_dflt = 1'b0;
  endtask : load

  task automatic cfg(input logic [3:0] k, input logic [10:0] id);
    i_cfg_kind = k;
    i_cfg_id = id;
    i_cfg_wr = 1'b1;
    step(1);
    i_cfg_wr = 1'b0;
  endtask : cfg

  // Next frame taken by the node, compared under a data mask
  task automatic frame(input logic [10:0] id, input logic [3:0] len,
                       input logic [31:0] d, input logic [31:0] m);
    int k;
    k = 0;
    while (i_cob_node_model.cap_cnt == seen && k < 200) begin
      step(1);
      k++;
    end
    // No frame taken in time counts as a mismatch
    if (k >= 200) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, i_cob_node_model.cap_cnt, seen + 1);
    end
    seen = i_cob_node_model.cap_cnt;
    chk({i_cob_node_model.cap_id, i_cob_node_model.cap_len, i_cob_node_model.cap_data & m},
        {id, len, d & m});
  endtask : frame

  task automatic sdo(input logic [10:0] id);
    i_sdo_cmd = 8'h40;
    i_sdo_index = 16'h2010;
    i_sdo_sub = 8'h03;
    i_sdo_req = 1'b1;
    step(1);
    i_sdo_req = 1'b0;
    frame(id, 4'h4, 32'h0320_1040, 32'hffff_ffff);
  endtask : sdo

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_addr();
    load(7'h00);
    chk(o_addr_err, 1'b1);
    rx(11'h705);
    chk({o_rx_hit, o_rx_kind}, 5'h1d);
    load(7'h7f);
    rx(11'h77f);
    chk({o_addr_err, o_rx_hit, o_rx_kind}, 6'h1d);
    load(7'h05);
  endtask : t_addr

  task automatic t_tx();
    i_nmt_cmd = 8'h81;
    i_nmt_req = 1'b1;
    step(1);
    i_nmt_req = 1'b0;
    frame(11'h000, 4'h2, 32'h0000_0581, 32'h0000_ffff);
    i_sync_en = 1'b1;
    frame(11'h080, 4'h0, 32'h0000_0000, 32'h0000_0000);
    i_sync_en = 1'b0;
    step(2 * SYNC_N);
    seen = i_cob_node_model.cap_cnt;
    for (int n = 0; n < 4; n++) begin
      i_pdo_num = 2'(n);
      i_pdo_data = 32'hc3a5_0000 + 32'(n);
      i_pdo_req = 1'b1;
      step(1);
      i_pdo_req = 1'b0;
      frame({4'(4 + 2 * n), 7'h05}, 4'h4, i_pdo_data, 32'hffff_ffff);
    end
    sdo(11'h605);
  endtask : t_tx

  // All three pending at once under a slow accept
  task automatic t_prio();
    i_cob_node_model.dly = 3;
    i_nmt_cmd = 8'h02;
    i_pdo_num = 2'h1;
    {i_nmt_req, i_pdo_req, i_sdo_req} = 3'b111;
    step(1);
    {i_nmt_req, i_pdo_req, i_sdo_req} = 3'b000;
    frame(11'h000, 4'h2, 32'h0000_0502, 32'h0000_ffff);
    frame(11'h305, 4'h4, i_pdo_data, 32'hffff_ffff);
    frame(11'h605, 4'h4, 32'h0320_1040, 32'hffff_ffff);
    i_cob_node_model.dly = 0;
  endtask : t_prio

  task automatic t_rx();
    logic [3:0] fc [7] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hb, 4'he};
    logic [3:0] kd [7] = '{4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hb, 4'hd};
    logic [10:0] bad [4] = '{11'h000, 11'h080, 11'h205, 11'h186};
    for (int i = 0; i < 7; i++) begin
      rx({fc[i], 7'h05});
      chk({o_rx_hit, o_emcy_evt, o_rx_kind}, {1'b1, (i == 0), kd[i]});
    end
    for (int i = 0; i < 4; i++) begin
      rx(bad[i]);
      chk({o_rx_hit, o_emcy_evt, o_rx_kind}, 6'h0d);
    end
  endtask : t_rx

  task automatic t_reprog();
    cfg(4'h3, 11'h1a5);
    rx(11'h1a5);
    chk({o_rx_hit, o_rx_kind}, 5'h13);
    rx(11'h185);
    chk(o_rx_hit, 1'b0);
    cfg(4'hc, 11'h655);
    sdo(11'h655);
    load(7'h05);
  endtask : t_reprog

  task automatic t_lost();
    rx(11'h705);
    step(150);
    chk(o_node_lost, 1'b0);
    step(110);
    chk(o_node_lost, 1'b1);
    rx(11'h705);
    step(1);
    chk(o_node_lost, 1'b0);
  endtask : t_lost

  // Main sequence
  initial begin
    step(2);
    i_resetn = 1'b1;
    step(1);
    chk({o_tx_valid, o_rx_hit, o_emcy_evt, o_node_lost, o_addr_err, o_rx_kind}, 9'h000);
    load(7'h05);
    t_addr();
    t_tx();
    t_prio();
    t_rx();
    t_reprog();
    t_lost();
    test_done();
  end

  // Hang guard
  initial begin
    #40000;
    err_total++;
    test_done();
  end

endmodule : cob_host_test
